// ### rtl/nmt_map.svh
// constants of the node network-control block: defaults, object keys, identifiers
// assumes inclusion by bare name from the design files
`ifndef NMT_MAP_SVH
`define NMT_MAP_SVH

// node identity and bit-rate defaults
`define DEF_NODE   8'h20
`define NODE_MAX   8'h7F
`define DEF_TAB    1'b0
`define DEF_IDX    8'h04
`define DEF_RATE   11'h07D
`define RATE_MIN   11'h014
`define RATE_MAX   11'h5DC

// standard rate set, kbit/s (selector 0)
`define STD_R0     11'h3E8
`define STD_R1     11'h320
`define STD_R2     11'h1F4
`define STD_R3     11'h0FA
`define STD_R4     11'h07D
`define STD_R6     11'h032
`define STD_R7     11'h014
`define STD_R8     11'h00A
// factory custom rate set, kbit/s (selector 1)
`define CUS_R0     11'h5DC
`define CUS_R1     11'h190
`define CUS_R2     11'h064
`define CUS_R3     11'h00F

// object index keys, sub-index kept separately
`define OBJ_SYNC   16'h1005
`define OBJ_EMCY   16'h1014
`define OBJ_SDO    16'h1200
`define OBJ_TPDO   16'h1800
`define OBJ_ERRB   16'h1029
`define OBJ_NODE   16'h2000
`define OBJ_AUTO   16'h2001
`define OBJ_TERM   16'h2002

// communication object identifiers
`define NMT_COB    29'h0000_0000
`define BOOT_BASE  29'h0000_0700
`define SDORX_BASE 29'h0000_0600
`define SDOTX_BASE 29'h0000_0580
`define TPDO_BASE  29'h0000_0180
`define EMCY_BASE  29'h0000_0080
`define SYNC_COB   29'h0000_0080

// frame layout and codes
`define B0         63:56
`define B1         55:48
`define B2         47:40
`define NMT_LEN    4'h2
`define BOOT_LEN   4'h1
`define FULL_LEN   4'h8
`define CMD_START  8'h01
`define CMD_STOP   8'h02
`define CMD_PREOP  8'h80
`define CMD_RNODE  8'h81
`define CMD_RCOMM  8'h82
`define EMCY_CODE  16'h1000
`define EMCY_REG   8'h01
`define ERRB_PREOP 8'h00
`define ERRB_STOP  8'h02

`endif

// ### rtl/nmt_pkg.sv
// types shared by the node network-control block and its frame decoder
// assumes the constants of nmt_map.svh for values
package nmt_pkg;

  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_PREOP = 2'b01,
    ST_OPER  = 2'b10,
    ST_STOP  = 2'b11
  } nmt_state_t;

  typedef enum logic [2:0] {
    NC_NONE  = 3'b000,
    NC_START = 3'b001,
    NC_STOP  = 3'b010,
    NC_PREOP = 3'b011,
    NC_RNODE = 3'b100,
    NC_RCOMM = 3'b101
  } nmt_cmd_t;

  typedef enum logic [1:0] {
    LSS_NONE = 2'b00,
    LSS_NODE = 2'b01,
    LSS_RATE = 2'b10
  } lss_op_t;

  typedef struct packed {
    logic        ide;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } can_frame_t;

  typedef struct packed {
    logic        invalid;
    logic        rsvd;
    logic        ide;
    logic [28:0] id;
  } cob_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } sdo_wr_t;

  typedef struct packed {
    logic       valid;
    lss_op_t    op;
    logic [7:0] sel;
    logic [7:0] val;
  } lss_cmd_t;

  typedef struct packed {
    logic nmt, heartbeat_consumer, time_svc, lss, emcy, sdo, sync, pdo;
  } svc_t;

  typedef struct packed {
    nmt_cmd_t   cmd;
    logic       sdo_hit;
    logic       sync_hit;
    logic [3:0] len;
  } dec_state_t;

  typedef struct packed {
    nmt_state_t  st;
    svc_t        svc;
    logic        meas;
    logic        boot_pend;
    logic        emcy_pend;
    logic        tx_busy;
    logic        tx_boot;
    logic [7:0]  node;
    logic        rate_tab;
    logic [7:0]  rate_idx;
    logic [10:0] rate;
    cob_t        sdo_rx, sdo_tx, tpdo, emcy, sync;
    logic [7:0]  err_beh;
    logic        autostart;
    logic        term;
    can_frame_t  tx;
    logic        wr_ok, wr_err, lss_ok, lss_err;
  } core_state_t;

endpackage : nmt_pkg

// ### rtl/frame_decode.sv
// received-frame decoder: network commands and identifier matches
// assumes one received frame per rx_valid pulse, synchronous to core_clk
`timescale 1ns/1ns
`include "nmt_map.svh"

module frame_decode (
  // clock and synchronised reset
  input  wire logic                core_clk,
  input  wire logic                rst_sync_n,
  // received frame
  input  wire logic                rx_valid,
  input  wire nmt_pkg::can_frame_t rx_frame,
  // node configuration
  input  wire logic [7:0]          node,
  input  wire nmt_pkg::cob_t       cob_sdo,
  input  wire nmt_pkg::cob_t       cob_sync,
  input  wire nmt_pkg::svc_t       svc,
  // decoded pulses
  output nmt_pkg::dec_state_t      dec
);
  import nmt_pkg::*;

  dec_state_t q, next_q;

  // a frame hits an object only in the same format and identifier
  function automatic logic hit(input cob_t c, input can_frame_t f);
    logic same;
    same = f.ide ? (f.id == c.id) : (f.id[10:0] == c.id[10:0]);
    return !c.invalid && (c.ide == f.ide) && same;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode, gated by the services that the state allows
  always_comb begin
    next_q = '0;
    if (rx_valid) begin
      next_q.len = (rx_frame.dlc > `FULL_LEN) ? `FULL_LEN : rx_frame.dlc;
      if (svc.nmt && !rx_frame.ide && rx_frame.id == `NMT_COB
          && next_q.len == `NMT_LEN
          && (rx_frame.data[`B1] == 8'h00 || rx_frame.data[`B1] == node)) begin
        case (rx_frame.data[`B0])
          `CMD_START: next_q.cmd = NC_START;
          `CMD_STOP:  next_q.cmd = NC_STOP;
          `CMD_PREOP: next_q.cmd = NC_PREOP;
          `CMD_RNODE: next_q.cmd = NC_RNODE;
          `CMD_RCOMM: next_q.cmd = NC_RCOMM;
          default:    next_q.cmd = NC_NONE;
        endcase
      end
      next_q.sdo_hit  = svc.sdo && hit(cob_sdo, rx_frame);
      next_q.sync_hit = svc.sync && hit(cob_sync, rx_frame);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dec = q;

endmodule : frame_decode

// ### rtl/node_ctrl.sv
// node network control: state machine, boot-up and emergency frames,
// node identifier, bit-rate selection, object identifiers, termination
// assumes a frame controller outside that sends tx_frame on tx_req and
// pulses tx_ack, and an object-access layer that presents decoded writes
//
// Operation
// - bit rate is kept within 20 kbit/s to 1.5 Mbit/s inclusive
// - all bus nodes share one bit rate; one rate drives the controller
// - reset and default bit rate is 125 kbit/s
// - rate changes by layer setting; selector 0 standard, 1 factory custom
// - base 11-bit and extended 29-bit frames are accepted and produced
// - data length gives payload bytes, zero up to eight
// - node identifier is 8 bits, valid 1 to 127
// - default node identifier is 0x20
// - node identifier writable by object write and by layer setting
// - every object identifier is rewritable by object write
// - four states; boot-up frame sent, then Pre-Operational
// - Pre-Operational keeps measuring but sends no process data
// - start command id 0x000, length 2, bytes 01 00 enters Operational
// - autostart goes straight to Operational after boot-up
// - services offered depend on the state as tabled
// - no state change on its own except autostart or fault
// - a fault drops to Pre-Operational or Stopped per error behaviour
// - settings addressed by 16-bit index and 8-bit sub-index writes
// - termination enable settable by object write
`timescale 1ns/1ns
`include "nmt_map.svh"

module node_ctrl (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // received frames
  input  wire logic                rx_valid,
  input  wire nmt_pkg::can_frame_t rx_frame,
  output nmt_pkg::dec_state_t      rx_dec,
  // transmit request
  output logic                     tx_req,
  output nmt_pkg::can_frame_t      tx_frame,
  input  wire logic                tx_ack,
  // decoded object writes
  input  wire nmt_pkg::sdo_wr_t    sdo_wr,
  output logic                     sdo_wr_ok,
  output logic                     sdo_wr_err,
  // layer setting commands
  input  wire nmt_pkg::lss_cmd_t   lss_cmd,
  output logic                     lss_ok,
  output logic                     lss_err,
  // application
  input  wire logic                sensor_fault,
  output logic                     measure_en,
  // status and configuration
  output nmt_pkg::nmt_state_t      nmt_state,
  output nmt_pkg::svc_t            svc_en,
  output logic [7:0]               node_id,
  output logic [10:0]              bit_rate_kbps,
  output logic                     rate_table,
  output logic [7:0]               rate_index,
  output logic                     term_en
);
  import nmt_pkg::*;

  logic [1:0]  rst_sync;
  logic        rst_sync_n;
  core_state_t q, next_q;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // node-relative object identifier, base format, enabled
  function automatic cob_t cob_at(input logic [28:0] base,
                                  input logic [7:0] nd);
    cob_t c;
    c = '0;
    c.id = base + {21'h0, nd};
    return c;
  endfunction

  // services per state
  function automatic svc_t svc_of(input nmt_state_t s);
    svc_t v;
    v = '0;
    unique case (s)
      ST_INIT: v = '0;
      ST_PREOP: v = '{nmt: 1'b1, heartbeat_consumer: 1'b1, time_svc: 1'b1, lss: 1'b1,
                      emcy: 1'b1, sdo: 1'b1, sync: 1'b0, pdo: 1'b0};
      ST_OPER:  v = '{nmt: 1'b1, heartbeat_consumer: 1'b1, time_svc: 1'b1, lss: 1'b1,
                      emcy: 1'b1, sdo: 1'b1, sync: 1'b1, pdo: 1'b1};
      ST_STOP:  v = '{nmt: 1'b1, heartbeat_consumer: 1'b1, time_svc: 1'b1, lss: 1'b1,
                      emcy: 1'b0, sdo: 1'b0, sync: 1'b0, pdo: 1'b0};
    endcase
    return v;
  endfunction

  // rate tables in kbit/s; zero marks an empty entry
  function automatic logic [10:0] rate_of(input logic tab,
                                          input logic [7:0] idx);
    logic [10:0] r;
    r = 11'h000;
    if (!tab) begin
      case (idx)
        8'h00: r = `STD_R0;
        8'h01: r = `STD_R1;
        8'h02: r = `STD_R2;
        8'h03: r = `STD_R3;
        8'h04: r = `STD_R4;
        8'h06: r = `STD_R6;
        8'h07: r = `STD_R7;
        8'h08: r = `STD_R8;
        default: r = 11'h000;
      endcase
    end else begin
      case (idx)
        8'h00: r = `CUS_R0;
        8'h01: r = `CUS_R1;
        8'h02: r = `CUS_R2;
        8'h03: r = `CUS_R3;
        default: r = 11'h000;
      endcase
    end
    return r;
  endfunction

  // communication reset: identifiers rebuilt from the node, sync back to its fixed one, boot-up redone
  function automatic core_state_t comm_init(input core_state_t s);
    core_state_t t;
    t = s;
    t.st        = ST_INIT;
    t.boot_pend = 1'b1;
    t.emcy_pend = 1'b0;
    t.sdo_rx    = cob_at(`SDORX_BASE, s.node);
    t.sdo_tx    = cob_at(`SDOTX_BASE, s.node);
    t.tpdo      = cob_at(`TPDO_BASE, s.node);
    t.emcy      = cob_at(`EMCY_BASE, s.node);
    t.sync      = cob_at(`SYNC_COB, 8'h00);
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // received-frame decoder
  frame_decode u_decode (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .rx_valid   (rx_valid),
    .rx_frame   (rx_frame),
    .node       (q.node),
    .cob_sdo    (q.sdo_rx),
    .cob_sync   (q.sync),
    .svc        (q.svc),
    .dec        (rx_dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [23:0] key;
    logic [10:0] r;
    key    = {sdo_wr.index, sdo_wr.sub};
    r      = rate_of(lss_cmd.sel[0], lss_cmd.val);
    next_q = q;
    next_q.wr_ok   = 1'b0;
    next_q.wr_err  = 1'b0;
    next_q.lss_ok  = 1'b0;
    next_q.lss_err = 1'b0;

    // transmitter: finish first, then load boot-up ahead of emergency
    if (q.tx_busy && tx_ack) begin
      next_q.tx_busy = 1'b0;
      if (q.tx_boot) begin
        next_q.boot_pend = 1'b0;
        next_q.st = q.autostart ? ST_OPER : ST_PREOP;
      end else begin
        next_q.emcy_pend = 1'b0;
      end
    end else if (!q.tx_busy && q.boot_pend) begin
      next_q.tx_busy = 1'b1;
      next_q.tx_boot = 1'b1;
      next_q.tx      = '0;
      next_q.tx.id   = `BOOT_BASE + {21'h0, q.node};
      next_q.tx.dlc  = `BOOT_LEN;
    end else if (!q.tx_busy && q.emcy_pend) begin
      next_q.tx_busy = 1'b1;
      next_q.tx_boot = 1'b0;
      next_q.tx      = '0;
      next_q.tx.ide  = q.emcy.ide;
      next_q.tx.id   = q.emcy.id;
      next_q.tx.dlc  = `FULL_LEN;
      {next_q.tx.data[`B1], next_q.tx.data[`B0]} = `EMCY_CODE; // low byte first
      next_q.tx.data[`B2] = `EMCY_REG;
    end

    // master commands; only the master or a fault moves the node otherwise
    if (q.st != ST_INIT) begin
      unique case (rx_dec.cmd)
        NC_NONE:  ;
        NC_START: next_q.st = ST_OPER;
        NC_STOP:  next_q.st = ST_STOP;
        NC_PREOP: next_q.st = ST_PREOP;
        NC_RNODE: begin
          next_q = comm_init(next_q);
          next_q.err_beh = `ERRB_PREOP;
        end
        NC_RCOMM: next_q = comm_init(next_q);
        default:  ;
      endcase
    end

    // fault fallback outranks a same-cycle command, for safety
    if (sensor_fault && q.st != ST_INIT) begin
      if (q.svc.emcy && !q.emcy.invalid) begin
        next_q.emcy_pend = 1'b1; // set wins over the ack clear
      end
      if (q.err_beh == `ERRB_STOP) begin
        next_q.st = ST_STOP;
      end else if (q.err_beh == `ERRB_PREOP && next_q.st == ST_OPER) begin
        next_q.st = ST_PREOP;
      end
    end

    // object writes, only while the object-access service is offered
    if (sdo_wr.valid && q.svc.sdo) begin
      next_q.wr_ok = 1'b1;
      case (key)
        {`OBJ_NODE, 8'h00}: begin
          if (sdo_wr.data[31:8] == 24'h00_0000 && sdo_wr.data[7:0] != 8'h00
              && sdo_wr.data[7:0] <= `NODE_MAX) begin
            next_q.node = sdo_wr.data[7:0];
          end else begin
            next_q.wr_ok  = 1'b0;
            next_q.wr_err = 1'b1;
          end
        end
        {`OBJ_SDO, 8'h01}:  next_q.sdo_rx = sdo_wr.data;
        {`OBJ_SDO, 8'h02}:  next_q.sdo_tx = sdo_wr.data;
        {`OBJ_TPDO, 8'h01}: next_q.tpdo = sdo_wr.data;
        {`OBJ_SYNC, 8'h00}: next_q.sync = sdo_wr.data;
        {`OBJ_EMCY, 8'h00}: next_q.emcy = sdo_wr.data;
        {`OBJ_ERRB, 8'h01}: next_q.err_beh = sdo_wr.data[7:0];
        {`OBJ_AUTO, 8'h00}: next_q.autostart = sdo_wr.data[0];
        {`OBJ_TERM, 8'h00}: next_q.term = sdo_wr.data[0];
        default: begin
          next_q.wr_ok  = 1'b0;
          next_q.wr_err = 1'b1;
        end
      endcase
    end

    // layer setting; the rate applies at once, so the master must
    // switch every node together
    if (lss_cmd.valid && q.svc.lss) begin
      next_q.lss_ok = 1'b1;
      unique case (lss_cmd.op)
        LSS_NONE: next_q.lss_ok = 1'b0;
        LSS_NODE: begin
          if (lss_cmd.val != 8'h00 && lss_cmd.val <= `NODE_MAX) begin
            next_q.node = lss_cmd.val;
          end else begin
            next_q.lss_ok  = 1'b0;
            next_q.lss_err = 1'b1;
          end
        end
        LSS_RATE: begin
          if (lss_cmd.sel <= 8'h01 && r >= `RATE_MIN && r <= `RATE_MAX) begin
            next_q.rate     = r;
            next_q.rate_tab = lss_cmd.sel[0];
            next_q.rate_idx = lss_cmd.val;
          end else begin
            next_q.lss_ok  = 1'b0;
            next_q.lss_err = 1'b1;
          end
        end
        default: begin
          next_q.lss_ok  = 1'b0;
          next_q.lss_err = 1'b1;
        end
      endcase
    end

    // services and measurement follow the new state
    next_q.svc  = svc_of(next_q.st);
    next_q.meas = (next_q.st != ST_INIT);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset lands in initialisation with boot-up queued
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q           <= '0;
      q.st        <= ST_INIT;
      q.boot_pend <= 1'b1;
      q.node      <= `DEF_NODE;
      q.rate      <= `DEF_RATE;
      q.rate_tab  <= `DEF_TAB;
      q.rate_idx  <= `DEF_IDX;
      q.sdo_rx    <= cob_at(`SDORX_BASE, `DEF_NODE);
      q.sdo_tx    <= cob_at(`SDOTX_BASE, `DEF_NODE);
      q.tpdo      <= cob_at(`TPDO_BASE, `DEF_NODE);
      q.emcy      <= cob_at(`EMCY_BASE, `DEF_NODE);
      q.sync      <= cob_at(`SYNC_COB, 8'h00);
      q.err_beh   <= `ERRB_PREOP;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign tx_req        = q.tx_busy;
  assign tx_frame      = q.tx;
  assign sdo_wr_ok     = q.wr_ok;
  assign sdo_wr_err    = q.wr_err;
  assign lss_ok        = q.lss_ok;
  assign lss_err       = q.lss_err;
  assign measure_en    = q.meas;
  assign nmt_state     = q.st;
  assign svc_en        = q.svc;
  assign node_id       = q.node;
  assign bit_rate_kbps = q.rate;
  assign rate_table    = q.rate_tab;
  assign rate_index    = q.rate_idx;
  assign term_en       = q.term;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_boot_load;
    !q.tx_busy && q.boot_pend;
  endsequence

  sequence s_boot_done;
    q.st == ST_INIT && q.tx_busy && q.tx_boot && tx_ack;
  endsequence

  a_rate_range: assert property (bit_rate_kbps >= `RATE_MIN && bit_rate_kbps <= `RATE_MAX)
    else $error("bit rate left the supported span");

  a_default_rate: assert property ($rose(rst_sync_n) |-> bit_rate_kbps == `DEF_RATE)
    else $error("bit rate not at default after reset");

  a_default_node: assert property ($rose(rst_sync_n) |-> node_id == `DEF_NODE)
    else $error("node identifier not at default after reset");

  a_node_range: assert property (node_id != 8'h00 && node_id <= `NODE_MAX)
    else $error("node identifier outside 1 to 127");

  a_boot_frame: assert property (s_boot_load |=> tx_req && !tx_frame.ide
      && tx_frame.id == `BOOT_BASE + {21'h0, $past(q.node)} && tx_frame.dlc == `BOOT_LEN)
    else $error("boot-up frame malformed");

  a_boot_preop: assert property (s_boot_done ##0 !q.autostart |=> nmt_state == ST_PREOP)
    else $error("boot-up did not settle in pre-operational");

  a_autostart: assert property (s_boot_done ##0 q.autostart |=> nmt_state == ST_OPER)
    else $error("autostart did not reach operational");

  a_start_cmd: assert property (q.st != ST_INIT && rx_dec.cmd == NC_START
      && !sensor_fault |=> nmt_state == ST_OPER)
    else $error("start command ignored");

  a_no_self: assert property (q.st != ST_INIT && rx_dec.cmd == NC_NONE && !sensor_fault
      |=> $stable(nmt_state))
    else $error("state changed without cause");

  a_fault_stop: assert property (q.st != ST_INIT && sensor_fault
      && q.err_beh == `ERRB_STOP |=> nmt_state == ST_STOP)
    else $error("fault did not stop the node");

  a_svc_gate: assert property (svc_en.pdo == (nmt_state == ST_OPER)
      && svc_en.sdo == (nmt_state inside {ST_PREOP, ST_OPER})
      && svc_en.lss == (nmt_state != ST_INIT))
    else $error("service offered in wrong state");

  a_preop_meas: assert property (nmt_state == ST_PREOP |-> measure_en && !svc_en.pdo)
    else $error("pre-operational measurement gating wrong");

  a_node_reject: assert property (sdo_wr.valid && q.svc.sdo && !lss_cmd.valid
      && sdo_wr.index == `OBJ_NODE && sdo_wr.sub == 8'h00 && sdo_wr.data == 32'h0000_0000
      |=> $stable(node_id) && sdo_wr_err)
    else $error("invalid node identifier accepted");

endmodule : node_ctrl

// ### verif/nmt_master.sv
// partner: network master that answers node frames and sends commands
// assumes node outputs move on rising core_clk edges
`timescale 1ns/1ns

module nmt_master (
  // clock and answer delay
  input  wire logic                core_clk,
  input  wire logic [3:0]          ack_dly,
  // frames from the node
  input  wire logic                tx_req,
  input  wire nmt_pkg::can_frame_t tx_frame,
  output logic                     tx_ack,
  // frames to the node
  output logic                     rx_valid,
  output nmt_pkg::can_frame_t      rx_frame
);
  import nmt_pkg::*;
  int         frames = 0;
  int         wait_n = 0;
  can_frame_t last;

  initial begin
    tx_ack   = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  ////////////////////////////////////////
  // one ack pulse per frame, after ack_dly cycles, so slow answers are seen too
  always @(negedge core_clk) begin
    if (tx_req && !tx_ack && wait_n >= ack_dly) begin
      tx_ack <= 1'b1;
      last   <= tx_frame;
      frames <= frames + 1;
      wait_n <= 0;
    end else begin
      tx_ack <= 1'b0;
      wait_n <= tx_req ? wait_n + 1 : 0;
    end
  end

  // one frame per pulse; the idle line shows the inverse, never a stale copy
  task automatic send(input logic ide, input logic [28:0] id, input logic [3:0] dlc,
                      input logic [63:0] data);
    @(negedge core_clk);
    rx_frame = {ide, id, dlc, data};
    rx_valid = 1'b1;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_frame = ~rx_frame;
  endtask : send
endmodule : nmt_master

// ### verif/tb_node_ctrl.sv
// bench for node_ctrl: boot, commands, faults, identifiers, bit rates
// assumes nmt_pkg and nmt_master compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end

module tb_node_ctrl;
  import nmt_pkg::*;
  logic        core_clk, rst_n, sensor_fault, rx_valid, tx_req, tx_ack, exp_tab;
  logic        sdo_wr_ok, sdo_wr_err, lss_ok, lss_err, measure_en, rate_table, term_en;
  logic [3:0]  ack_dly;
  logic [7:0]  node_id, rate_index, v, exp_node, exp_idx;
  logic [10:0] bit_rate_kbps, r, exp_rate;
  logic [31:0] seed = 32'h0000_0FA5;
  int          miscompares = 0;
  int          checks_done = 0;
  can_frame_t  rx_frame, tx_frame;
  dec_state_t  rx_dec;
  sdo_wr_t     sdo_wr;
  lss_cmd_t    lss_cmd;
  nmt_state_t  nmt_state;
  svc_t        svc_en;
  // refused entries read zero: empty, or outside the supported span
  localparam logic [10:0] STD_KB [9] = '{11'h3E8, 11'h320, 11'h1F4, 11'h0FA, 11'h07D,
    11'h000, 11'h032, 11'h014, 11'h000};
  localparam logic [10:0] CUS_KB [4] = '{11'h5DC, 11'h190, 11'h064, 11'h000};

  node_ctrl uut (.core_clk, .rst_n, .rx_valid, .rx_frame, .rx_dec, .tx_req, .tx_frame,
    .tx_ack, .sdo_wr, .sdo_wr_ok, .sdo_wr_err, .lss_cmd, .lss_ok, .lss_err, .sensor_fault,
    .measure_en, .nmt_state, .svc_en, .node_id, .bit_rate_kbps, .rate_table, .rate_index,
    .term_en);
  nmt_master m (.core_clk, .ack_dly, .tx_req, .tx_frame, .tx_ack, .rx_valid, .rx_frame);

  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [10:0] rate_exp(input int s, input int i);
    if (s == 0 && i < 9) return STD_KB[i];
    if (s == 1 && i < 4) return CUS_KB[i];
    return 11'h000;
  endfunction : rate_exp

  // nmt hbc time lss emcy sdo sync pdo
  function automatic svc_t svc_exp(input nmt_state_t s);
    case (s)
      ST_PREOP: return 8'hFC;
      ST_OPER:  return 8'hFF;
      ST_STOP:  return 8'hF0;
      default:  return 8'h00;
    endcase
  endfunction : svc_exp

  // writes enter one cycle after the last one left, so no signal moves twice at once
  task automatic sdo(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                     input logic ok);
    @(negedge core_clk);
    sdo_wr = {1'b1, idx, sub, d};
    @(negedge core_clk);
    sdo_wr.valid = 1'b0;
    `CHK("sdo_wr_ok", ok, sdo_wr_ok)
    `CHK("sdo_wr_err", !ok, sdo_wr_err)
  endtask : sdo

  task automatic lss(input lss_op_t op, input logic [7:0] sel, input logic [7:0] val,
                     input logic ok);
    @(negedge core_clk);
    lss_cmd = {1'b1, op, sel, val};
    @(negedge core_clk);
    lss_cmd.valid = 1'b0;
    `CHK("lss_ok", ok, lss_ok)
    `CHK("lss_err", !ok, lss_err)
  endtask : lss

  task automatic nmt(input logic [7:0] cmd, input logic [7:0] tgt);
    m.send(1'b0, 29'h0, 4'h2, {cmd, tgt, 48'h0});
    @(negedge core_clk);
  endtask : nmt

  task automatic fault();
    @(negedge core_clk);
    sensor_fault = 1'b1;
    @(negedge core_clk);
    sensor_fault = 1'b0;
  endtask : fault

  task automatic st_is(input nmt_state_t s);
    for (int i = 0; i < 40 && nmt_state !== s; i++) @(negedge core_clk);
    `CHK("nmt_state", s, nmt_state)
    `CHK("svc_en", svc_exp(s), svc_en)
    `CHK("measure_en", s != ST_INIT, measure_en)
  endtask : st_is

  // waits for the next acknowledged frame; a one-byte frame shows byte 0 only
  task automatic frm_is(input logic [28:0] id, input logic [3:0] dlc, input logic [23:0] b);
    int n;
    n = m.frames;
    for (int i = 0; i < 60 && m.frames == n; i++) @(negedge core_clk);
    `CHK("tx_id", id, m.last.id)
    `CHK("tx_dlc", dlc, m.last.dlc)
    `CHK("tx_bytes", b, dlc == 4'h1 ? {m.last.data[63:56], 16'h0000} : m.last.data[63:40])
  endtask : frm_is

  task automatic conclude();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // tests take a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end

  initial begin
    {rst_n, sensor_fault, sdo_wr, lss_cmd, ack_dly} = '0;
    {exp_tab, exp_idx, exp_rate} = {1'b0, 8'h04, 11'h07D};
    repeat (8) @(negedge core_clk);
    st_is(ST_INIT);
    `CHK("node_id", 8'h20, node_id)
    `CHK("bit_rate", exp_rate, bit_rate_kbps)
    rst_n = 1'b1;
    ack_dly = 4'h3;
    frm_is(29'h720, 4'h1, 24'h0);
    st_is(ST_PREOP);
    // wrong target, extended format, wrong length, unknown code: all ignored
    m.send(1'b0, 29'h0, 4'h2, 64'h0121_0000_0000_0000);
    m.send(1'b1, 29'h0, 4'h2, 64'h0100_0000_0000_0000);
    m.send(1'b0, 29'h0, 4'h3, 64'h0100_0000_0000_0000);
    m.send(1'b0, 29'h0, 4'h2, 64'h0700_0000_0000_0000);
    m.send(1'b0, 29'h620, 4'h8, 64'h0);
    `CHK("sdo_hit", 1'b1, rx_dec.sdo_hit)
    @(negedge core_clk);
    st_is(ST_PREOP);
    $display("test boot_and_commands done");
    ack_dly = 4'(rnd());
    fault();
    frm_is(29'h0A0, 4'h8, 24'h00_1001);
    st_is(ST_PREOP);
    nmt(8'h01, 8'h00);
    st_is(ST_OPER);
    sdo(16'h1014, 8'h00, 32'h2000_1234, 1'b1);
    fault();
    frm_is(29'h1234, 4'h8, 24'h00_1001);
    `CHK("tx_ide", 1'b1, m.last.ide)
    st_is(ST_PREOP);
    sdo(16'h1029, 8'h01, 32'h0000_0002, 1'b1);
    nmt(8'h01, 8'h20);
    st_is(ST_OPER);
    fault();
    frm_is(29'h1234, 4'h8, 24'h00_1001);
    st_is(ST_STOP);
    nmt(8'h80, 8'h00);
    st_is(ST_PREOP);
    $display("test faults done");
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 10; i++) begin
        r = rate_exp(s, i);
        lss(LSS_RATE, 8'(s), 8'(i), r != 0);
        if (r != 0) {exp_tab, exp_idx, exp_rate} = {s[0], 8'(i), r};
        `CHK("bit_rate", exp_rate, bit_rate_kbps)
        `CHK("rate_sel", {exp_tab, exp_idx}, {rate_table, rate_index})
      end
    end
    $display("test bit_rates done");
    // both write paths, boundaries first, then random values
    exp_node = 8'h20;
    for (int i = 0; i < 20; i++) begin
      v = i == 0 ? 8'h00 : i == 1 ? 8'h80 : i == 2 ? 8'h7F : i == 3 ? 8'h01 : 8'(rnd());
      if (i[0]) lss(LSS_NODE, 8'h00, v, v != 0 && v < 8'h80);
      else sdo(16'h2000, 8'h00, {24'h0, v}, v != 0 && v < 8'h80);
      if (v != 0 && v < 8'h80) exp_node = v;
      `CHK("node_id", exp_node, node_id)
    end
    sdo(16'h2000, 8'h00, 32'h0000_0105, 1'b0);
    sdo(16'h3000, 8'h00, 32'h0000_0000, 1'b0);
    sdo(16'h2002, 8'h00, 32'h0000_0001, 1'b1);
    `CHK("term_en", 1'b1, term_en)
    `CHK("node_id", exp_node, node_id)
    $display("test node_id done");
    sdo(16'h2001, 8'h00, 32'h0000_0001, 1'b1);
    ack_dly = 4'h2;
    nmt(8'h82, exp_node);
    st_is(ST_INIT);
    frm_is(29'h700 + exp_node, 4'h1, 24'h0);
    st_is(ST_OPER);
    $display("test autostart done");
    conclude();
  end
endmodule : tb_node_ctrl
